// *** rpmh_regs.svh ***
// Purpose: Register map, field positions, codes and timing figures of the protection message handler
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef RPMH_REGS_SVH
`define RPMH_REGS_SVH
`define RPMH_A_CTRL     8'h00
`define RPMH_A_FAST     8'h04
`define RPMH_A_SLOW     8'h08
`define RPMH_A_CMD      8'h0c
`define RPMH_A_STAT     8'h10
`define RPMH_A_RXI      8'h14
`define RPMH_A_MACL     8'h18
`define RPMH_A_MACH     8'h1c
`define RPMH_B_EN       0
`define RPMH_B_WCAP     1
`define RPMH_B_WRAPPED  2
`define RPMH_B_STEER    3
`define RPMH_B_REQ0     4
`define RPMH_B_REQ1     8
`define RPMH_B_DISC     0
`define RPMH_B_NEWST    1
`define RPMH_B_WC       7
`define RPMH_B_WSC      6
`define RPMH_B_RSVD     5
`define RPMH_B_PI       4
`define RPMH_REQ_FS     4'hd
`define RPMH_REQ_SF     4'hb
`define RPMH_REQ_SD     4'h8
`define RPMH_REQ_MS     4'h6
`define RPMH_REQ_WTR    4'h5
`define RPMH_REQ_IDLE   4'h0
`define RPMH_CTYPE      8'h02
`define RPMH_BCAST      48'hffff_ffff_ffff
`define RPMH_FAST_DEF   5'h0a
`define RPMH_FAST_MIN   5'h01
`define RPMH_FAST_MAX   5'h14
`define RPMH_SLOW_DEF   8'h02
`define RPMH_SLOW_MIN   8'h01
`define RPMH_SLOW_MAX   8'hc8
`define RPMH_SLOW_STEP  14'h0032
`define RPMH_FAST_CNT   4'h8
`define RPMH_MS_NS      1000000
`define RPMH_CLK_NS     50
`endif

// *** rpmh_pkg.sv ***
// Purpose: Types of the protection message handler
// Assumes: Constants come from rpmh_regs.svh
// Notes:   All module state sits in one packed struct
package rpmh_pkg;
  typedef enum logic [1:0] {ST_WAIT, ST_SEND0, ST_SEND1} rpmh_st_e;
  typedef struct packed {
    logic        en;
    logic        wcap;
    logic        wrapped;
    logic        steer;
    logic [3:0]  req0;
    logic [3:0]  req1;
    logic [4:0]  fast;
    logic [7:0]  slow;
    logic [47:0] mac;
    rpmh_st_e    st;
    logic        pend;
    logic [3:0]  fcnt;
    logic [19:0] mscnt;
    logic [13:0] per;
    logic [5:0]  cin;
    logic [6:0]  sent;
    logic [7:0]  seq;
    logic [7:0]  tx_byte;
    logic        tx_pi1;
    logic        upd;
    logic        topo_rl;
    logic [7:0]  topo_byte;
    logic [7:0]  topo_seq;
    logic [47:0] topo_sa;
    logic        disc;
    logic        strip;
    logic [1:0]  miscab;
    logic [1:0]  nonop;
    logic        rdy;
    logic [31:0] rdata;
  } rpmh_state_s;
endpackage

// *** rpmh_handler.sv ***
// Purpose: Builds, schedules, sends and receives ring protection messages
// Assumes: Single clock, APB register access, sequence check done by the topology store
// Notes:   Contract
// Contract
// - Broadcast destination, own source address
// - Wrap-eligible header bit always zero
// - Control kind field equals two
// - Sent on every ringlet, max TTL, source strips
// - Wrap capable bit reflects capability
// - Wrap status one when wrapped, zero steering
// - Bit five reserved, no meaning
// - Path indicator zero short, one long
// - Short path opposite ringlet, long same ringlet
// - Request type codes as listed
// - Sequence increments only on content change
// - Send on discovery, change, new station, periodically
// - Capability change waits for periodic send
// - Fast period 1 to 20 ms
// - First eight messages at fast spacing
// - Slow period 50 ms to 10 s
// - Triggers restart fast phase, then slow
// - Same-ringlet message updates topology if sequence ok
// - Neighbour ringlet mismatch: discard, link down, error
// - Wrapped station strips, never wraps messages
// - Messages flow in any protection state
// - Request priority FS, SF, SD, MS, WAIT_TO_RESTORE
// - Correct ringlet from neighbour clears miscabling
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "rpmh_regs.svh"
module rpmh_handler #(
  parameter int         P_MS_CYC = `RPMH_MS_NS / `RPMH_CLK_NS,
  parameter logic [7:0] P_MAXST  = 8'hff
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_TX_VALID,
  input  wire logic        I_TX_READY,
  output logic             O_TX_RINGLET,
  output logic      [47:0] O_TX_DA,
  output logic      [47:0] O_TX_SA,
  output logic             O_TX_WE,
  output logic      [7:0]  O_TX_CTYPE,
  output logic      [7:0]  O_TX_TTL,
  output logic             O_TX_STRIP,
  output logic      [7:0]  O_TX_PBYTE,
  output logic      [7:0]  O_TX_SEQ,
  input  wire logic        I_RX_VALID,
  input  wire logic        I_RX_RINGLET,
  input  wire logic        I_RX_RID,
  input  wire logic [7:0]  I_RX_TTL,
  input  wire logic [7:0]  I_RX_CTYPE,
  input  wire logic [47:0] I_RX_SA,
  input  wire logic [7:0]  I_RX_PBYTE,
  input  wire logic [7:0]  I_RX_SEQ,
  input  wire logic        I_RX_SEQ_OK,
  output logic             O_TOPO_UPD,
  output logic             O_TOPO_RINGLET,
  output logic      [7:0]  O_TOPO_PBYTE,
  output logic      [7:0]  O_TOPO_SEQ,
  output logic      [47:0] O_TOPO_SA,
  output logic             O_RX_DISCARD,
  output logic             O_RX_STRIP,
  output logic      [1:0]  O_MISCABLE,
  output logic      [1:0]  O_LINK_NONOP
);
  import rpmh_pkg::*;

  localparam logic [19:0] MS_LAST = 20'(P_MS_CYC - 1);

  // Rank of a request type, higher wins
  function automatic logic [2:0] req_rank(input logic [3:0] r);
    case (r)
      `RPMH_REQ_FS:  req_rank = 3'h5;
      `RPMH_REQ_SF:  req_rank = 3'h4;
      `RPMH_REQ_SD:  req_rank = 3'h3;
      `RPMH_REQ_MS:  req_rank = 3'h2;
      `RPMH_REQ_WTR: req_rank = 3'h1;
      default:       req_rank = 3'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `RPMH_A_CTRL) || (a == `RPMH_A_FAST) || (a == `RPMH_A_SLOW) ||
             (a == `RPMH_A_CMD)  || (a == `RPMH_A_STAT) || (a == `RPMH_A_RXI)  ||
             (a == `RPMH_A_MACL) || (a == `RPMH_A_MACH);
  endfunction

  localparam rpmh_state_s RST = '{
    en: 1'b0, wcap: 1'b0, wrapped: 1'b0, steer: 1'b0,
    req0: `RPMH_REQ_IDLE, req1: `RPMH_REQ_IDLE,
    fast: `RPMH_FAST_DEF, slow: `RPMH_SLOW_DEF, mac: 48'h0,
    st: ST_WAIT, pend: 1'b0, fcnt: 4'h0, mscnt: 20'h0, per: 14'h0,
    cin: 6'h0, sent: 7'h0, seq: 8'h00, tx_byte: 8'h00, tx_pi1: 1'b0,
    upd: 1'b0, topo_rl: 1'b0, topo_byte: 8'h00, topo_seq: 8'h00,
    topo_sa: 48'h0, disc: 1'b0, strip: 1'b0, miscab: 2'h0, nonop: 2'h0,
    rdy: 1'b0, rdata: 32'h0};

  rpmh_state_s s_r;
  rpmh_state_s s_nxt;

  logic        side_w;
  logic [3:0]  req_w;
  logic        wrap_status_field;
  logic [5:0]  cin;
  logic        trig;
  logic        acc;
  logic        wr;
  logic        wr_pend;
  logic [13:0] target;
  logic        expire;
  logic        rx_ok;
  logic        rx_nb;
  logic        pi0;
  logic        pi1;

  always_comb begin
    side_w = req_rank(s_r.req1) > req_rank(s_r.req0);
    req_w  = side_w ? s_r.req1 : s_r.req0;
    wrap_status_field    = s_r.wrapped & ~s_r.steer;
    // Capability bit kept out of the trigger content
    cin    = {req_w, side_w, wrap_status_field};
    trig   = s_r.en && (cin != s_r.cin);
    acc    = I_PSEL && I_PENABLE && !s_r.rdy;
    // Writes land at the edge where the ready answer is sampled
    wr     = I_PSEL && I_PENABLE && s_r.rdy && I_PWRITE;
    wr_pend = wr && (((I_PADDR == `RPMH_A_CMD) && s_r.en &&
                      (I_PWDATA[`RPMH_B_DISC] || I_PWDATA[`RPMH_B_NEWST])) ||
                     ((I_PADDR == `RPMH_A_CTRL) && I_PWDATA[`RPMH_B_EN] && !s_r.en));
    target = (s_r.fcnt < `RPMH_FAST_CNT) ? {9'h0, s_r.fast} :
             14'(s_r.slow * `RPMH_SLOW_STEP);
    expire = (s_r.mscnt == MS_LAST) && (s_r.per >= target - 14'h1);
    // Long path goes out on the ringlet whose link holds the request
    pi0    = (req_w != `RPMH_REQ_IDLE) && !side_w;
    pi1    = (req_w != `RPMH_REQ_IDLE) && side_w;
    rx_ok  = I_RX_VALID && (I_RX_CTYPE == `RPMH_CTYPE);
    rx_nb  = I_RX_TTL == P_MAXST;
  end

  always_comb begin
    s_nxt     = s_r;
    s_nxt.cin = cin;
    s_nxt.rdy = acc;
    s_nxt.upd = 1'b0;
    s_nxt.disc = 1'b0;
    s_nxt.strip = 1'b0;
    if (acc) begin
      case (I_PADDR)
        `RPMH_A_CTRL: s_nxt.rdata = {20'h0, s_r.req1, s_r.req0, s_r.steer, s_r.wrapped, s_r.wcap, s_r.en};
        `RPMH_A_FAST: s_nxt.rdata = {27'h0, s_r.fast};
        `RPMH_A_SLOW: s_nxt.rdata = {24'h0, s_r.slow};
        `RPMH_A_STAT: s_nxt.rdata = {16'h0, s_r.fcnt, s_r.nonop, s_r.miscab, s_r.seq};
        `RPMH_A_RXI:  s_nxt.rdata = {15'h0, s_r.topo_rl, s_r.topo_seq, s_r.topo_byte};
        `RPMH_A_MACL: s_nxt.rdata = s_r.mac[31:0];
        `RPMH_A_MACH: s_nxt.rdata = {16'h0, s_r.mac[47:32]};
        default:      s_nxt.rdata = 32'h0;
      endcase
    end
    if (trig) begin
      s_nxt.pend = 1'b1;
    end
    if (wr) begin
      case (I_PADDR)
        `RPMH_A_CTRL: begin
          s_nxt.en      = I_PWDATA[`RPMH_B_EN];
          s_nxt.wcap    = I_PWDATA[`RPMH_B_WCAP];
          s_nxt.wrapped = I_PWDATA[`RPMH_B_WRAPPED];
          s_nxt.steer   = I_PWDATA[`RPMH_B_STEER];
          s_nxt.req0    = I_PWDATA[`RPMH_B_REQ0 +: 4];
          s_nxt.req1    = I_PWDATA[`RPMH_B_REQ1 +: 4];
          // Enabling is initialisation and starts a fast phase
          if (I_PWDATA[`RPMH_B_EN] && !s_r.en) begin
            s_nxt.pend = 1'b1;
          end
        end
        `RPMH_A_FAST: begin
          if (I_PWDATA[4:0] >= `RPMH_FAST_MIN && I_PWDATA[4:0] <= `RPMH_FAST_MAX &&
              I_PWDATA[31:5] == 27'h0) begin
            s_nxt.fast = I_PWDATA[4:0];
          end
        end
        `RPMH_A_SLOW: begin
          if (I_PWDATA[7:0] >= `RPMH_SLOW_MIN && I_PWDATA[7:0] <= `RPMH_SLOW_MAX &&
              I_PWDATA[31:8] == 24'h0) begin
            s_nxt.slow = I_PWDATA[7:0];
          end
        end
        `RPMH_A_CMD: begin
          if (s_r.en && (I_PWDATA[`RPMH_B_DISC] || I_PWDATA[`RPMH_B_NEWST])) begin
            s_nxt.pend = 1'b1;
          end
        end
        `RPMH_A_MACL: s_nxt.mac[31:0] = I_PWDATA;
        `RPMH_A_MACH: s_nxt.mac[47:32] = I_PWDATA[15:0];
        default: ;
      endcase
    end
    case (s_r.st)
      ST_WAIT: begin
        if (s_r.en) begin
          s_nxt.mscnt = (s_r.mscnt == MS_LAST) ? 20'h0 : s_r.mscnt + 20'h1;
          if (s_r.mscnt == MS_LAST) begin
            s_nxt.per = s_r.per + 14'h1;
          end
        end else begin
          s_nxt.mscnt = 20'h0;
          s_nxt.per   = 14'h0;
        end
        if (s_r.en && (s_r.pend || trig || expire)) begin
          if (s_r.pend || trig) begin
            s_nxt.fcnt = 4'h0;
          end
          // A trigger written in this very cycle must survive the send start
          s_nxt.pend = wr_pend;
          if ({s_r.wcap, cin} != s_r.sent) begin
            s_nxt.seq = s_r.seq + 8'h01;
          end
          s_nxt.sent    = {s_r.wcap, cin};
          s_nxt.tx_byte = {s_r.wcap, wrap_status_field, 1'b0, pi0, req_w};
          s_nxt.tx_pi1  = pi1;
          s_nxt.st      = ST_SEND0;
        end
      end
      ST_SEND0: begin
        if (I_TX_READY) begin
          s_nxt.tx_byte[`RPMH_B_PI] = s_r.tx_pi1;
          s_nxt.st = ST_SEND1;
        end
      end
      ST_SEND1: begin
        if (I_TX_READY) begin
          s_nxt.st    = ST_WAIT;
          s_nxt.mscnt = 20'h0;
          s_nxt.per   = 14'h0;
          if (s_r.fcnt < `RPMH_FAST_CNT) begin
            s_nxt.fcnt = s_r.fcnt + 4'h1;
          end
        end
      end
      default: s_nxt.st = ST_WAIT;
    endcase
    // Receive side works whatever the protection state
    if (rx_ok) begin
      s_nxt.strip = s_r.wrapped || (I_RX_SA == s_r.mac);
      if (I_RX_RID != I_RX_RINGLET) begin
        s_nxt.disc = 1'b1;
        if (rx_nb) begin
          s_nxt.nonop[I_RX_RINGLET]  = 1'b1;
          s_nxt.miscab[I_RX_RINGLET] = 1'b1;
        end
      end else begin
        if (rx_nb && s_r.miscab[I_RX_RINGLET]) begin
          s_nxt.miscab[I_RX_RINGLET] = 1'b0;
          s_nxt.nonop[I_RX_RINGLET]  = 1'b0;
        end
        if (I_RX_SEQ_OK) begin
          s_nxt.upd       = 1'b1;
          s_nxt.topo_rl   = I_RX_RINGLET;
          // Reserved bit is dropped before the topology store sees it
          s_nxt.topo_byte = I_RX_PBYTE & ~(8'h01 << `RPMH_B_RSVD);
          s_nxt.topo_seq  = I_RX_SEQ;
          s_nxt.topo_sa   = I_RX_SA;
        end
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s_r <= RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign O_PRDATA       = s_r.rdata;
  assign O_PREADY       = I_PSEL && I_PENABLE && s_r.rdy;
  assign O_PSLVERR      = O_PREADY && !mapped(I_PADDR);
  assign O_TX_VALID     = (s_r.st == ST_SEND0) || (s_r.st == ST_SEND1);
  assign O_TX_RINGLET   = s_r.st == ST_SEND1;
  assign O_TX_DA        = `RPMH_BCAST;
  assign O_TX_SA        = s_r.mac;
  assign O_TX_WE        = 1'b0;
  assign O_TX_CTYPE     = `RPMH_CTYPE;
  assign O_TX_TTL       = P_MAXST;
  assign O_TX_STRIP     = 1'b1;
  assign O_TX_PBYTE     = s_r.tx_byte;
  assign O_TX_SEQ       = s_r.seq;
  assign O_TOPO_UPD     = s_r.upd;
  assign O_TOPO_RINGLET = s_r.topo_rl;
  assign O_TOPO_PBYTE   = s_r.topo_byte;
  assign O_TOPO_SEQ     = s_r.topo_seq;
  assign O_TOPO_SA      = s_r.topo_sa;
  assign O_RX_DISCARD   = s_r.disc;
  assign O_RX_STRIP     = s_r.strip;
  assign O_MISCABLE     = s_r.miscab;
  assign O_LINK_NONOP   = s_r.nonop;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence s_first_out;
    O_TX_VALID && I_TX_READY && !O_TX_RINGLET;
  endsequence
  sequence s_bad_nb;
    rx_ok && rx_nb && (I_RX_RID != I_RX_RINGLET);
  endsequence

  a_tx_addr: assert property (O_TX_VALID |-> O_TX_DA == `RPMH_BCAST && O_TX_SA == s_r.mac)
    else $error("tx address wrong");
  a_tx_ctrl: assert property (O_TX_VALID |-> !O_TX_WE && O_TX_CTYPE == `RPMH_CTYPE)
    else $error("tx header wrong");
  a_tx_ttl: assert property (O_TX_VALID |-> O_TX_TTL == P_MAXST && O_TX_STRIP)
    else $error("tx ttl wrong");
  a_rsvd_zero: assert property (O_TX_VALID |-> !O_TX_PBYTE[`RPMH_B_RSVD])
    else $error("reserved bit set");
  a_seq_pair: assert property (s_first_out |=> O_TX_VALID && O_TX_RINGLET && $stable(O_TX_SEQ))
    else $error("ringlet copies differ");
  a_pi_flip: assert property (s_first_out ##0 (O_TX_PBYTE[3:0] != `RPMH_REQ_IDLE)
      |=> O_TX_PBYTE[`RPMH_B_PI] != $past(O_TX_PBYTE[`RPMH_B_PI]))
    else $error("path indicator not split");
  a_trig_send: assert property (trig && s_r.st == ST_WAIT |=> O_TX_VALID && !O_TX_RINGLET)
    else $error("trigger not sent");
  a_miscable: assert property (s_bad_nb |=> O_RX_DISCARD && O_MISCABLE[$past(I_RX_RINGLET)])
    else $error("miscabling missed");
  a_topo_upd: assert property (rx_ok && I_RX_RID == I_RX_RINGLET && I_RX_SEQ_OK |=> O_TOPO_UPD)
    else $error("topology not updated");
  a_wrap_strip: assert property (rx_ok && s_r.wrapped |=> O_RX_STRIP)
    else $error("wrapped station kept message");
endmodule

// *** rpmh_peer.sv ***
// Purpose: Far-side model, a sink for sent copies and a source of received messages
// Assumes: Every accepted copy is logged in queues that the bench reads
// Notes:   Released receive lines show the inverse of their last value
`timescale 1ns/100ps
`include "rpmh_regs.svh"
module rpmh_peer (
  input  wire logic        i_clk,
  input  wire logic        i_tv,
  output logic             o_trdy,
  input  wire logic        i_trl,
  input  wire logic [47:0] i_tda,
  input  wire logic        i_twe,
  input  wire logic [7:0]  i_tct,
  input  wire logic [7:0]  i_tttl,
  input  wire logic        i_tstr,
  input  wire logic [7:0]  i_tpb,
  input  wire logic [7:0]  i_tsq,
  output logic             o_rv,
  output logic             o_rrl,
  output logic             o_rid,
  output logic [7:0]       o_rttl,
  output logic [7:0]       o_rct,
  output logic [47:0]      o_rsa,
  output logic [7:0]       o_rpb,
  output logic [7:0]       o_rsq,
  output logic             o_rok
);
  logic       slow    = 1'b0;
  logic       hdr_bad = 1'b0;
  int         cyc     = 0;
  int         cy[$];
  logic       rl[$];
  logic [7:0] pb[$];
  logic [7:0] sq[$];
  initial begin
    o_trdy = 1'b1;
    {o_rv, o_rrl, o_rid, o_rttl, o_rct, o_rsa, o_rpb, o_rsq, o_rok} = '0;
  end
  // Stalling mode accepts on every third cycle only
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    o_trdy <= !slow || (cyc % 3 == 0);
    if (i_tv === 1'b1 && o_trdy) begin
      cy.push_back(cyc);
      rl.push_back(i_trl);
      pb.push_back(i_tpb);
      sq.push_back(i_tsq);
      if (i_tda !== `RPMH_BCAST || i_twe !== 1'b0 || i_tct !== 8'h02 || i_tttl !== 8'hff || i_tstr !== 1'b1) begin
        hdr_bad <= 1'b1;
      end
    end
  end
  task automatic rx(input logic r, d, input logic [7:0] t, c, input logic [47:0] a, input logic [7:0] b, s,
                    input logic k);
    @(posedge i_clk);
    o_rv <= 1'b1;
    {o_rrl, o_rid, o_rttl, o_rct, o_rsa, o_rpb, o_rsq, o_rok} <= {r, d, t, c, a, b, s, k};
    @(posedge i_clk);
    o_rv <= 1'b0;
    {o_rrl, o_rid, o_rttl, o_rct, o_rsa, o_rpb, o_rsq, o_rok} <= ~{r, d, t, c, a, b, s, k};
  endtask
endmodule

// *** rpmh_handler_tb_top.sv ***
// Purpose: Self-checking bench of the protection message handler
// Assumes: One millisecond shortened to 20 cycles
// Notes:   Registers reached through APB tasks, traffic through the peer model
`timescale 1ns/100ps
`include "rpmh_regs.svh"
module rpmh_handler_tb_top;
  localparam logic [47:0] MAC = 48'h0a1b_2c3d_4e5f;
  localparam logic [47:0] OSA = 48'h0200_0000_0001;
  localparam logic [19:0] TBL [0:8] = '{20'h0d0d4, 20'h0b0b4, 20'h08084, 20'h06064, 20'h05054,
                                        20'h00000, 20'h08bb2, 20'h8b0b5, 20'hcb0b4};
  logic        clk, rstn, psel, penable, pwrite, prdy, perr, rerr;
  logic [7:0]  paddr, s, p0, p1;
  logic [31:0] pwdata, prd, rdat;
  logic        tv, trdy, trl, twe, tstr, rv, rrl, rid, rok, tupd, torl, rdis, rstr;
  logic [47:0] tda, tsa, rsa, tosa;
  logic [7:0]  tct, tttl, tpb, tsq, rttl, rct, rpb, rsq, topb, tosq;
  logic [1:0]  misc, nonop;
  logic [19:0] e;
  int          err_count, n_checks, cycles, n0, g;
  rpmh_handler #(.P_MS_CYC(20)) u_rpmh_handler (
    .I_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr), .O_TX_VALID(tv),
    .I_TX_READY(trdy), .O_TX_RINGLET(trl), .O_TX_DA(tda), .O_TX_SA(tsa), .O_TX_WE(twe), .O_TX_CTYPE(tct),
    .O_TX_TTL(tttl), .O_TX_STRIP(tstr), .O_TX_PBYTE(tpb), .O_TX_SEQ(tsq), .I_RX_VALID(rv),
    .I_RX_RINGLET(rrl), .I_RX_RID(rid), .I_RX_TTL(rttl), .I_RX_CTYPE(rct), .I_RX_SA(rsa), .I_RX_PBYTE(rpb),
    .I_RX_SEQ(rsq), .I_RX_SEQ_OK(rok), .O_TOPO_UPD(tupd), .O_TOPO_RINGLET(torl), .O_TOPO_PBYTE(topb),
    .O_TOPO_SEQ(tosq), .O_TOPO_SA(tosa), .O_RX_DISCARD(rdis), .O_RX_STRIP(rstr), .O_MISCABLE(misc),
    .O_LINK_NONOP(nonop));
  rpmh_peer u_rpmh_peer (
    .i_clk(clk), .i_tv(tv), .o_trdy(trdy), .i_trl(trl), .i_tda(tda), .i_twe(twe), .i_tct(tct),
    .i_tttl(tttl), .i_tstr(tstr), .i_tpb(tpb), .i_tsq(tsq), .o_rv(rv), .o_rrl(rrl), .o_rid(rid),
    .o_rttl(rttl), .o_rct(rct), .o_rsa(rsa), .o_rpb(rpb), .o_rsq(rsq), .o_rok(rok));
  always #25 clk = ~clk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [71:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    @(posedge clk);
    while (prdy !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk(prdy, 1'b1, "apb ready");
    rdat = prd;
    rerr = perr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d, x);
    apb(1'b1, a, d);
    apb(1'b0, a, 32'h0);
    chk(rdat, x, "register value");
  endtask
  task automatic ctrl(input logic wc, wr, st, input logic [3:0] r0, r1);
    apb(1'b1, `RPMH_A_CTRL, {20'h0, r1, r0, st, wr, wc, 1'b1});
  endtask
  task automatic wait_n(input int k);
    int t;
    t = 0;
    while (u_rpmh_peer.rl.size() < k && t < 3000) begin
      @(posedge clk);
      t++;
    end
    chk(t < 3000, 1'b1, "message wait");
  endtask
  task automatic msg_chk(input logic [7:0] a, b, q);
    int k;
    k = u_rpmh_peer.rl.size() - 1;
    if (u_rpmh_peer.rl[k] !== 1'b1) k--;
    chk({u_rpmh_peer.rl[k-1], u_rpmh_peer.rl[k]}, 2'b01, "copy ringlets");
    chk({u_rpmh_peer.pb[k-1], u_rpmh_peer.pb[k]}, {a, b}, "protection byte");
    chk({u_rpmh_peer.sq[k-1], u_rpmh_peer.sq[k]}, {q, q}, "sequence");
  endtask
  task automatic rxc(input logic r, d, input logic [7:0] t, c, input logic k, input logic [4:0] x);
    u_rpmh_peer.rx(r, d, t, c, OSA, 8'hff, 8'h33, k);
    #1;
    chk({tupd, rdis, rstr, misc}, x, "receive outputs");
    if (x[4]) chk({torl, topb, tosq, tosa}, {r, 8'hdf, 8'h33, OSA}, "topology image");
  endtask
  initial begin
    {clk, rstn, psel, penable, pwrite, paddr, pwdata, err_count, n_checks, cycles} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `RPMH_A_STAT, 32'h0);
    chk(rdat[9:0], 10'h0, "status after reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(rerr, 1'b1, "unmapped error");
    wrrd(`RPMH_A_FAST, 32'h0, 32'h0a);
    wrrd(`RPMH_A_FAST, 32'h15, 32'h0a);
    wrrd(`RPMH_A_FAST, 32'h14, 32'h14);
    wrrd(`RPMH_A_FAST, 32'h1, 32'h1);
    wrrd(`RPMH_A_SLOW, 32'h0, 32'h2);
    wrrd(`RPMH_A_SLOW, 32'hc9, 32'h2);
    wrrd(`RPMH_A_SLOW, 32'hc8, 32'hc8);
    wrrd(`RPMH_A_SLOW, 32'h1, 32'h1);
    apb(1'b1, `RPMH_A_MACL, MAC[31:0]);
    apb(1'b1, `RPMH_A_MACH, {16'h0, MAC[47:32]});
    ctrl(1'b0, 1'b0, 1'b0, 4'hb, 4'h0);
    wait_n(20);
    chk(tsa, MAC, "source address");
    s = u_rpmh_peer.sq[0];
    chk({u_rpmh_peer.rl[0], u_rpmh_peer.pb[0], u_rpmh_peer.pb[1]}, {1'b0, 16'h1b0b}, "first message");
    for (int m = 1; m < 10; m++) begin
      g = u_rpmh_peer.cy[2*m] - u_rpmh_peer.cy[2*m-2];
      chk(m < 8 ? (g >= 20 && g <= 24) : (g >= 1000 && g <= 1004), 1'b1, "period");
      chk(u_rpmh_peer.sq[2*m+1], s, "periodic sequence");
    end
    n0 = u_rpmh_peer.rl.size();
    ctrl(1'b1, 1'b0, 1'b0, 4'hb, 4'h0);
    repeat (300) @(posedge clk);
    chk(u_rpmh_peer.rl.size(), n0, "capability change quiet");
    wait_n(n0 + 2);
    s = s + 8'h1;
    msg_chk(8'h9b, 8'h8b, s);
    u_rpmh_peer.slow = 1'b1;
    for (int i = 0; i < 9; i++) begin
      e = TBL[i];
      ctrl(1'b1, e[19], e[18], e[15:12], e[11:8]);
      repeat (60) @(posedge clk);
      s = s + 8'h1;
      p0 = {1'b1, e[0], 1'b0, e[2], e[7:4]};
      p1 = {1'b1, e[0], 1'b0, e[1], e[7:4]};
      msg_chk(p0, p1, s);
    end
    u_rpmh_peer.slow = 1'b0;
    for (int c = 1; c < 3; c++) begin
      repeat (400) @(posedge clk);
      n0 = u_rpmh_peer.rl.size();
      apb(1'b1, `RPMH_A_CMD, c);
      repeat (60) @(posedge clk);
      chk(u_rpmh_peer.rl.size() >= n0 + 4, 1'b1, "command restarts fast sends");
      msg_chk(p0, p1, s);
    end
    ctrl(1'b1, 1'b0, 1'b0, 4'h0, 4'h0);
    rxc(1'b0, 1'b0, 8'hff, 8'h02, 1'b1, 5'b10000);
    rxc(1'b0, 1'b0, 8'hff, 8'h02, 1'b0, 5'b00000);
    rxc(1'b0, 1'b0, 8'hff, 8'h03, 1'b1, 5'b00000);
    rxc(1'b1, 1'b0, 8'hfe, 8'h02, 1'b1, 5'b01000);
    rxc(1'b1, 1'b0, 8'hff, 8'h02, 1'b1, 5'b01010);
    chk(nonop, 2'b10, "link down");
    rxc(1'b1, 1'b1, 8'hff, 8'h02, 1'b1, 5'b10000);
    chk(nonop, 2'b00, "link up");
    ctrl(1'b1, 1'b1, 1'b0, 4'h0, 4'h0);
    rxc(1'b0, 1'b0, 8'hff, 8'h02, 1'b1, 5'b10100);
    chk(u_rpmh_peer.hdr_bad, 1'b0, "frame header");
    stop_test();
  end
endmodule
